// [design/eii_ext_int.sv]
// external interrupt input: pin latch, status and control, AHB-Lite slave
// assumes a single AHB-Lite master and a cpu giving a vector fetch pulse
`include "eii_cfg.svh"

// Functional notes
// - falling pin edge sets the latch
// - vector fetch acknowledge clears the latch
// - software writing ack one clears latch
// - reset clears latch and mode bit
// - edge mode: acknowledge clears at once
// - level mode: acknowledge and pin high needed
// - level mode: pending while pin stays low
// - mask bit blocks forwarding to priority logic
// - pending flag readable regardless of mask
// - ack bit write-only, reads zero, reset clears
// - later falling edge after ack relatches
// - taken request vectors through FFFA and FFFB
// - break clear enabled: clears stick after break
// - break clear disabled: software ack ignored in break, vector fetch still clears
// - mask bit read/write, reset clears
// - mode bit read/write, one adds levels
// - pin level visible to branch instructions
module eii_ext_int
	import eii_pkg::*;
#(
	parameter int SYNC_STAGES = `EII_SYNC_STAGES  // pin synchroniser depth
) (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic        irq_pin_n,
	input  wire logic        vector_fetch,
	input  wire logic        break_state,
	output logic             cpu_irq_req,
	output logic [15:0]      cpu_irq_vector,
	output logic             pin_level,
	output logic             evt_irq
);

	// ---- pin front end
	logic pin_lvl;                 // synchronised pin level
	logic pin_fall;                // falling edge pulse

	eii_pin_sync #(
		.STAGES (SYNC_STAGES)
	) u_sync (
		.hclk    (hclk),
		.hresetn (hresetn),
		.pin_n   (irq_pin_n),
		.level   (pin_lvl),
		.fall    (pin_fall)
	);

	// ---- bus address phase capture
	logic        wr_pend_q;        // write data phase pending
	logic        rd_pend_q;        // read data phase pending
	logic [7:0]  addr_q;           // captured low address
	logic        acc_ok;           // valid transfer in address phase

	assign acc_ok = hsel & hready & htrans[1];

	// capture address phase of each accepted transfer
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_q <= 1'b0;
			rd_pend_q <= 1'b0;
			addr_q    <= 8'h00;
		end else if (hready) begin
			wr_pend_q <= acc_ok & hwrite;
			rd_pend_q <= acc_ok & ~hwrite;
			addr_q    <= haddr[7:0];
		end
	end

	// zero wait states, always okay
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	// ---- register state
	logic       mode_q;            // 1: edges plus low levels
	logic       interrupt_mask_bit_q;           // 1: forwarding disabled
	logic       brk_clr_en_q;      // break clear enable
	logic [1:0] evt_stat_q;        // sticky event bits
	logic [1:0] evt_mask_q;        // event interrupt enables
	eii_state_t state_q;           // latch state
	eii_state_t state_d;

	// decoded write strobes
	logic wr_sc;
	logic wr_brk;
	logic wr_evs;
	logic wr_evm;
	logic sw_ack;                  // effective software acknowledge
	logic ack;                     // any acknowledge this cycle

	// address decoding of writes
	always_comb begin
		wr_sc  = 1'b0;
		wr_brk = 1'b0;
		wr_evs = 1'b0;
		wr_evm = 1'b0;
		if (wr_pend_q && addr_q == `EII_OFF_SC) begin
			wr_sc = 1'b1;
		end else if (wr_pend_q && addr_q == `EII_OFF_BRK) begin
			wr_brk = 1'b1;
		end else if (wr_pend_q && addr_q == `EII_OFF_EVT_STAT) begin
			wr_evs = 1'b1;
		end else if (wr_pend_q && addr_q == `EII_OFF_EVT_MASK) begin
			wr_evm = 1'b1;
		end
	end

	// ack write ignored in break unless break clear enabled
	assign sw_ack = wr_sc & hwdata[`EII_SC_ACK] & (~break_state | brk_clr_en_q);
	assign ack    = sw_ack | vector_fetch;

	// mode and mask bits
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mode_q  <= 1'(`EII_SC_RST >> `EII_SC_MODE);
			interrupt_mask_bit_q <= 1'b0;
		end else if (wr_sc) begin
			mode_q  <= hwdata[`EII_SC_MODE];
			interrupt_mask_bit_q <= hwdata[`EII_SC_INTERRUPT_MASK_BIT];
		end
	end

	// break clear enable
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			brk_clr_en_q <= `EII_BRK_RST;
		end else if (wr_brk) begin
			brk_clr_en_q <= hwdata[`EII_BRK_CLR_EN];
		end
	end

	// ---- interrupt latch state machine
	always_comb begin
		state_d = state_q;
		case (state_q)
			EII_IDLE: begin
				if (pin_fall) begin
					state_d = EII_PEND;
				end
			end
			EII_PEND: begin
				if (ack && mode_q && !pin_lvl) begin
					state_d = EII_HOLD;
				end else if (ack) begin
					state_d = EII_IDLE;
				end
			end
			EII_HOLD: begin
				if (!mode_q || pin_lvl) begin
					state_d = pin_fall ? EII_PEND : EII_IDLE;
				end
			end
			default: begin
				state_d = EII_IDLE;
			end
		endcase
		// a new edge after the acknowledge relatches
		if (pin_fall && state_q != EII_IDLE && !ack) begin
			state_d = EII_PEND;
		end
	end

	// latch state register
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_q <= EII_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// ---- outputs to the cpu
	logic pending;                 // request present
	assign pending = (state_q != EII_IDLE);

	// request forwarded only while unmasked
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cpu_irq_req <= 1'b0;
		end else begin
			cpu_irq_req <= (state_d != EII_IDLE) & ~(wr_sc ? hwdata[`EII_SC_INTERRUPT_MASK_BIT] : interrupt_mask_bit_q);
		end
	end

	// vector address and pin level
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cpu_irq_vector <= `EII_VEC_HI;
			pin_level      <= 1'b1;
		end else begin
			cpu_irq_vector <= `EII_VEC_HI;
			pin_level      <= pin_lvl;
		end
	end

	// ---- event status and interrupt
	logic [1:0] evt_now;           // events this cycle
	assign evt_now[`EII_EV_SET] = (state_q == EII_IDLE) & (state_d != EII_IDLE);
	assign evt_now[`EII_EV_CLR] = (state_q != EII_IDLE) & (state_d == EII_IDLE);

	// sticky bits, write one clears, set wins
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			evt_stat_q <= 2'h0;
		end else begin
			evt_stat_q <= (evt_stat_q & ~(wr_evs ? hwdata[1:0] : 2'h0)) | evt_now;
		end
	end

	// event mask register
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			evt_mask_q <= `EII_EVM_RST;
		end else if (wr_evm) begin
			evt_mask_q <= hwdata[1:0];
		end
	end

	// level interrupt from unmasked sticky events
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			evt_irq <= 1'b0;
		end else begin
			evt_irq <= |(((evt_stat_q & ~(wr_evs ? hwdata[1:0] : 2'h0)) | evt_now)
				& (wr_evm ? hwdata[1:0] : evt_mask_q));
		end
	end

	// ---- read data
	logic [31:0] rdata;

	// read mux; ack reads zero, unmapped reads zero
	always_comb begin
		rdata = 32'h0000_0000;
		if (addr_q == `EII_OFF_SC) begin
			rdata[`EII_SC_MODE]  = mode_q;
			rdata[`EII_SC_INTERRUPT_MASK_BIT] = interrupt_mask_bit_q;
			rdata[`EII_SC_ACK]   = 1'b0;
			rdata[`EII_SC_PEND]  = pending;
		end else if (addr_q == `EII_OFF_BRK) begin
			rdata[`EII_BRK_CLR_EN] = brk_clr_en_q;
		end else if (addr_q == `EII_OFF_EVT_STAT) begin
			rdata[1:0] = evt_stat_q;
		end else if (addr_q == `EII_OFF_EVT_MASK) begin
			rdata[1:0] = evt_mask_q;
		end else if (addr_q == `EII_OFF_PIN) begin
			rdata[0] = pin_lvl;
		end else if (addr_q == `EII_OFF_VEC) begin
			rdata[15:0] = `EII_VEC_HI;
		end
	end

	assign hrdata = rd_pend_q ? rdata : 32'h0000_0000;

	// ---- checks
	AST_FALL_SETS: assert property (@(posedge hclk) disable iff (!hresetn)
		(pin_fall && state_q == EII_IDLE) |=> pending)
		else $error("falling edge did not set latch");

	AST_VF_CLEARS_EDGE: assert property (@(posedge hclk) disable iff (!hresetn)
		(vector_fetch && !mode_q && state_q == EII_PEND && !pin_fall) |=> !pending)
		else $error("vector fetch did not clear latch");

	AST_SW_ACK: assert property (@(posedge hclk) disable iff (!hresetn)
		(wr_sc && hwdata[`EII_SC_ACK] && !break_state && !mode_q && !pin_fall) |=> !pending)
		else $error("software ack did not clear latch");

	AST_LEVEL_HOLD: assert property (@(posedge hclk) disable iff (!hresetn)
		(mode_q && pending && !pin_lvl && !wr_sc) |=> pending)
		else $error("level request dropped while pin low");

	AST_MASK: assert property (@(posedge hclk) disable iff (!hresetn)
		interrupt_mask_bit_q && !wr_sc |=> !cpu_irq_req)
		else $error("masked request forwarded");

	AST_FWD: assert property (@(posedge hclk) disable iff (!hresetn)
		(!interrupt_mask_bit_q && !wr_sc && state_d != EII_IDLE) |=> cpu_irq_req)
		else $error("unmasked request not forwarded");

	AST_BRK_PROTECT: assert property (@(posedge hclk) disable iff (!hresetn)
		(break_state && !brk_clr_en_q && !vector_fetch && state_q == EII_PEND) |=> pending)
		else $error("latch cleared in protected break");

	AST_ACK_READ0: assert property (@(posedge hclk) disable iff (!hresetn)
		rd_pend_q |-> !hrdata[`EII_SC_ACK] || addr_q != `EII_OFF_SC)
		else $error("ack bit read as one");

	AST_PIN_LEVEL: assert property (@(posedge hclk) disable iff (!hresetn)
		##1 pin_level == $past(pin_lvl))
		else $error("pin level output stale");

	AST_IDLE_STAYS: assert property (@(posedge hclk) disable iff (!hresetn)
		(state_q == EII_IDLE && !pin_fall) |=> !pending)
		else $error("latch set without a falling edge");

	AST_LEVEL_ACK: assert property (@(posedge hclk) disable iff (!hresetn)
		(state_q == EII_PEND && ack && mode_q && !pin_lvl) |=> state_q == EII_HOLD)
		else $error("level request not held after acknowledge");

	AST_LEVEL_RELEASE: assert property (@(posedge hclk) disable iff (!hresetn)
		(state_q == EII_HOLD && pin_lvl) |=> !pending)
		else $error("level request kept after pin release");

	AST_RELATCH: assert property (@(posedge hclk) disable iff (!hresetn)
		(pin_fall && !ack) |=> pending)
		else $error("falling edge after acknowledge not latched");

	AST_BRK_CLEAR: assert property (@(posedge hclk) disable iff (!hresetn)
		(wr_sc && hwdata[`EII_SC_ACK] && break_state && brk_clr_en_q && !mode_q && !pin_fall) |=> !pending)
		else $error("enabled break clear did not clear latch");

	AST_MASK_WRITE: assert property (@(posedge hclk) disable iff (!hresetn)
		wr_sc |=> interrupt_mask_bit_q == $past(hwdata[`EII_SC_INTERRUPT_MASK_BIT]))
		else $error("mask bit write not taken");

	AST_MODE_WRITE: assert property (@(posedge hclk) disable iff (!hresetn)
		wr_sc |=> mode_q == $past(hwdata[`EII_SC_MODE]))
		else $error("mode bit write not taken");

	AST_PEND_READ: assert property (@(posedge hclk) disable iff (!hresetn)
		(rd_pend_q && addr_q == `EII_OFF_SC) |-> hrdata[`EII_SC_PEND] == pending)
		else $error("pending flag read wrong");

	AST_PIN_READ: assert property (@(posedge hclk) disable iff (!hresetn)
		(rd_pend_q && addr_q == `EII_OFF_PIN) |-> hrdata[0] == pin_lvl)
		else $error("pin level read wrong");

	AST_EVT_SET: assert property (@(posedge hclk) disable iff (!hresetn)
		evt_now[`EII_EV_SET] |=> evt_stat_q[`EII_EV_SET])
		else $error("latch set event not recorded");

endmodule : eii_ext_int

// [design/eii_cfg.svh]
// offsets, field positions, reset values and timing counts of the external interrupt block
// assumes a 32-bit AHB-Lite register bus, one aligned word per register
`ifndef EII_CFG_SVH
`define EII_CFG_SVH

// register byte addresses
`define EII_OFF_SC        8'h00
`define EII_OFF_BRK       8'h04
`define EII_OFF_EVT_STAT  8'h08
`define EII_OFF_EVT_MASK  8'h0C
`define EII_OFF_PIN       8'h10
`define EII_OFF_VEC       8'h14

// status and control field positions
`define EII_SC_MODE       0
`define EII_SC_INTERRUPT_MASK_BIT      1
`define EII_SC_ACK        2
`define EII_SC_PEND       3

// break flag control field position
`define EII_BRK_CLR_EN    0

// event bits: latch set, latch cleared
`define EII_EV_SET        0
`define EII_EV_CLR        1
`define EII_EV_W          2

// reset values
`define EII_SC_RST        8'h00
`define EII_BRK_RST       1'b0
`define EII_EVM_RST       2'h0

// interrupt vector addresses
`define EII_VEC_HI        16'hFFFA
`define EII_VEC_LO        16'hFFFB

// synchroniser depth
`define EII_SYNC_STAGES   2

`endif

// [design/eii_pkg.sv]
// types shared by the external interrupt block
// assumes eii_cfg.svh holds the numeric constants
package eii_pkg;

	// latch states, gray coded along idle -> pending -> acked
	typedef enum logic [1:0] {
		EII_IDLE  = 2'b00,   // nothing latched
		EII_PEND  = 2'b01,   // request latched
		EII_HOLD  = 2'b11    // acknowledged, pin still low in level mode
	} eii_state_t;

	// ahb transfer types
	typedef enum logic [1:0] {
		EII_HT_IDLE   = 2'b00,
		EII_HT_BUSY   = 2'b01,
		EII_HT_NONSEQ = 2'b10,
		EII_HT_SEQ    = 2'b11
	} eii_htrans_t;

endpackage : eii_pkg

// [design/eii_pin_sync.sv]
// pin synchroniser and falling edge detector for the external interrupt pin
// assumes the pin idles high through an external pullup
module eii_pin_sync #(
	parameter int STAGES = 2      // synchroniser depth
) (
	input  wire logic hclk,
	input  wire logic hresetn,
	input  wire logic pin_n,       // raw active low pin
	output logic      level,       // synchronised pin level
	output logic      fall         // one-cycle falling edge pulse
);

	logic [STAGES-1:0] sync_q;    // synchroniser chain, resets to idle high
	logic              last_q;    // previous synchronised sample
	logic [STAGES:0]   vld_q;     // stages holding real samples taken since reset

	// mark chain stages as real once a sample has reached them after reset;
	// the preset high must not pair with a pin already low into a false edge
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			vld_q <= '0;
		end else begin
			vld_q <= {vld_q[STAGES-1:0], 1'b1};
		end
	end

	// shift the pin through the chain; only the next stage reads stage 0
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sync_q <= '1;
		end else begin
			sync_q <= {sync_q[STAGES-2:0], pin_n};
		end
	end

	// remember the last synchronised sample
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			last_q <= 1'b1;
		end else begin
			last_q <= sync_q[STAGES-1];
		end
	end

	assign level = sync_q[STAGES-1];
	// high sample followed by low sample
	assign fall  = vld_q[STAGES] & last_q & ~sync_q[STAGES-1];

endmodule : eii_pin_sync

// [testbench/eii_src_model.sv]
// behavioural external source that drives the active low interrupt pin
// assumes the bench commands the level; a released pin is pulled high
module eii_src_model (
	input  wire logic       hclk,
	input  wire logic       hold_low,   // command: pull the pin low
	input  wire logic [3:0] lag,        // cycles before the pin follows
	output logic            irq_pin_n   // active low pin
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [3:0] cnt_q;                  // cycles waited so far
	initial begin
		irq_pin_n = 1'b1;
		cnt_q = 4'h0;
	end
	// pin follows the command late or promptly; released means pullup high
	always @(posedge hclk) begin
		if (irq_pin_n === hold_low) begin
			if (cnt_q >= lag) begin
				irq_pin_n <= ~hold_low;
				cnt_q <= 4'h0;
			end else begin
				cnt_q <= cnt_q + 4'h1;
			end
		end else begin
			cnt_q <= 4'h0;
		end
	end
endmodule : eii_src_model

// [testbench/tb_top.sv]
// self-checking bench for the external interrupt block
// assumes eii_src_model drives the pin and the bench is the only bus master
`include "eii_cfg.svh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin miscompares++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top
	import eii_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic        hclk, hresetn;         // clock, reset
	logic        hsel, hwrite;          // select, direction
	eii_htrans_t htrans;                // transfer type
	logic [2:0]  hsize;                 // transfer size
	logic [31:0] haddr, hwdata, hrdata; // address and data
	logic        hreadyout, hresp;      // slave answer
	logic        vector_fetch, break_state, hold_low; // cpu and source controls
	logic [3:0]  lag;                   // source delay
	logic        irq_pin_n, cpu_irq_req, pin_level, evt_irq;
	logic [15:0] cpu_irq_vector;        // vector address
	logic [31:0] rd, seed;              // last read, random state
	int          miscompares, compares;
	logic [7:0]  ra [7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h1C};   // reset walk
	logic [31:0] re [7] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h1, 32'hFFFA, 32'h0};

	eii_ext_int #(.SYNC_STAGES(2)) uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .irq_pin_n(irq_pin_n), .vector_fetch(vector_fetch),
		.break_state(break_state), .cpu_irq_req(cpu_irq_req), .cpu_irq_vector(cpu_irq_vector),
		.pin_level(pin_level), .evt_irq(evt_irq));
	eii_src_model src (.hclk(hclk), .hold_low(hold_low), .lag(lag), .irq_pin_n(irq_pin_n));

	// xorshift step
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction : xs
	// expected status and control word
	function automatic logic [31:0] sc(input logic mode, input logic mask, input logic pend);
		return {28'h0, pend, 1'b0, mask, mode};
	endfunction : sc
	// verdict and end of run
	task automatic test_done();
		$display("counts: compares=%0d miscompares=%0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : test_done
	// wait for hready high at a rising edge, bounded
	task automatic wrdy();
		for (int n = 0; n < 16; n++) begin
			@(posedge hclk);
			if (hreadyout === 1'b1) return;
		end
		miscompares++;
		test_done();
	endtask : wrdy
	// one single word transfer; read data lands in rd
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= EII_HT_NONSEQ;
		haddr <= {24'h0, a};
		hwrite <= w;
		wrdy();
		hsel <= 1'b0;
		htrans <= EII_HT_IDLE;
		hwdata <= d;
		wrdy();
		rd = hrdata;
	endtask : bus
	// poll the pending flag until it reads p
	task automatic poll(input logic p);
		for (int n = 0; n < 24; n++) begin
			bus(1'b0, `EII_OFF_SC, 32'h0);
			if (rd[`EII_SC_PEND] === p) return;
		end
		miscompares++;
		test_done();
	endtask : poll
	// one cycle vector fetch pulse
	task automatic vf();
		@(posedge hclk);
		vector_fetch <= 1'b1;
		@(posedge hclk);
		vector_fetch <= 1'b0;
	endtask : vf
	// read status and control after a settle time
	task automatic rsc(input logic [31:0] e);
		repeat (6) @(posedge hclk);
		bus(1'b0, `EII_OFF_SC, 32'h0);
		`CHK(rd, e)
	endtask : rsc

	// free running clock
	initial begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end
	// hang guard
	initial begin
		repeat (60000) @(posedge hclk);
		miscompares++;
		test_done();
	end
	// main sequence
	initial begin
		hresetn = 1'b0; hsel = 1'b0; htrans = EII_HT_IDLE; haddr = 32'h0; hwrite = 1'b0; hsize = 3'b010;
		hwdata = 32'h0; vector_fetch = 1'b0; break_state = 1'b0; hold_low = 1'b0; lag = 4'h0;
		seed = 32'd61203; miscompares = 0; compares = 0;
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		foreach (ra[i]) begin
			bus(1'b0, ra[i], 32'h0);
			`CHK(rd, re[i])
		end
		`CHK(cpu_irq_vector, 16'hFFFA)
		`CHK(hresp, 1'b0)
		$display("reset test done");
		// edge mode: fall latches, fetch clears even with the pin low
		bus(1'b1, `EII_OFF_EVT_MASK, 32'h3);
		hold_low <= 1'b1;
		poll(1'b1);
		`CHK(cpu_irq_req, 1'b1)
		`CHK(evt_irq, 1'b1)
		bus(1'b0, `EII_OFF_PIN, 32'h0);
		`CHK(rd[0], 1'b0)
		`CHK(pin_level, 1'b0)
		vf();
		repeat (2) @(posedge hclk);
		`CHK(cpu_irq_req, 1'b0)
		rsc(sc(1'b0, 1'b0, 1'b0));
		bus(1'b0, `EII_OFF_EVT_STAT, 32'h0);
		`CHK(rd, 32'h3)
		bus(1'b1, `EII_OFF_EVT_STAT, 32'h3);
		bus(1'b1, `EII_OFF_EVT_MASK, 32'h0);
		repeat (2) @(posedge hclk);
		`CHK(evt_irq, 1'b0)
		$display("edge test done");
		// masked request, software clear, relatch after clear
		bus(1'b1, `EII_OFF_SC, sc(1'b0, 1'b1, 1'b0));
		hold_low <= 1'b0;
		repeat (8) @(posedge hclk);
		hold_low <= 1'b1;
		poll(1'b1);
		`CHK(cpu_irq_req, 1'b0)
		bus(1'b1, `EII_OFF_SC, 32'h6);
		rsc(sc(1'b0, 1'b1, 1'b0));
		hold_low <= 1'b0;
		repeat (8) @(posedge hclk);
		hold_low <= 1'b1;
		poll(1'b1);
		bus(1'b1, `EII_OFF_SC, 32'h4);
		poll(1'b0);
		$display("mask test done");
		// level mode, both orders of acknowledge and pin release
		hold_low <= 1'b0;
		bus(1'b1, `EII_OFF_SC, sc(1'b1, 1'b0, 1'b0));
		repeat (8) @(posedge hclk);
		hold_low <= 1'b1;
		poll(1'b1);
		bus(1'b1, `EII_OFF_SC, sc(1'b1, 1'b1, 1'b0));
		vf();
		rsc(sc(1'b1, 1'b1, 1'b1));
		hold_low <= 1'b0;
		poll(1'b0);
		hold_low <= 1'b1;
		poll(1'b1);
		hold_low <= 1'b0;
		rsc(sc(1'b1, 1'b1, 1'b1));
		bus(1'b1, `EII_OFF_SC, 32'h7);
		poll(1'b0);
		$display("level test done");
		// break state: clear refused, then allowed and kept
		bus(1'b1, `EII_OFF_SC, 32'h0);
		hold_low <= 1'b1;
		poll(1'b1);
		break_state <= 1'b1;
		bus(1'b1, `EII_OFF_SC, 32'h4);
		rsc(sc(1'b0, 1'b0, 1'b1));
		bus(1'b1, `EII_OFF_BRK, 32'h1);
		bus(1'b1, `EII_OFF_SC, 32'h4);
		poll(1'b0);
		break_state <= 1'b0;
		rsc(sc(1'b0, 1'b0, 1'b0));
		hold_low <= 1'b0;
		$display("break test done");
		// random control words, acknowledge kept low
		for (int i = 0; i < 40; i++) begin
			seed = xs(seed);
			lag <= seed[7:4];
			break_state <= seed[8];
			bus(1'b1, `EII_OFF_SC, seed & 32'hFFFFFFFB);
			bus(1'b0, `EII_OFF_SC, 32'h0);
			`CHK(rd, sc(seed[0], seed[1], 1'b0))
		end
		break_state <= 1'b0;
		$display("random test done");
		// reset while latched with the pin low
		bus(1'b1, `EII_OFF_SC, sc(1'b1, 1'b0, 1'b0));
		hold_low <= 1'b1;
		poll(1'b1);
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		`CHK(cpu_irq_req, 1'b0)
		hresetn <= 1'b1;
		rsc(sc(1'b0, 1'b0, 1'b0));
		`CHK(cpu_irq_req, 1'b0)
		$display("reset again test done");
		test_done();
	end
endmodule : tb_top
